// ===== design/irq_agg_pkg.sv
`default_nettype none
package irq_agg_pkg;
  localparam int unsigned GROUP_FIRST   = 8;
  localparam int unsigned GROUP_LAST    = 26;
  localparam int unsigned GROUP_COUNT   = GROUP_LAST - GROUP_FIRST + 1;
  localparam int unsigned SRC_BITS      = 31;
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned GROUP_STRIDE  = 20;
  localparam logic [ADDR_W-1:0] OFS_SOURCE    = 10'h000;
  localparam logic [ADDR_W-1:0] OFS_EN_SET    = 10'h004;
  localparam logic [ADDR_W-1:0] OFS_RESULT    = 10'h008;
  localparam logic [ADDR_W-1:0] OFS_EN_CLEAR  = 10'h00c;
  localparam logic [ADDR_W-1:0] OFS_GROUP_END = 10'h174;
  localparam logic [ADDR_W-1:0] OFS_BLK_SET   = 10'h200;
  localparam logic [ADDR_W-1:0] OFS_BLK_CLEAR = 10'h204;
  localparam logic [ADDR_W-1:0] OFS_BLK_VEC   = 10'h208;
  localparam logic [SRC_BITS-1:0]    SRC_RESET = 31'h0;
  localparam logic [GROUP_COUNT-1:0] BLK_RESET = 19'h0;

  typedef logic [SRC_BITS-1:0] src_vec_t;

  typedef struct packed {
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [3:0]           sel;
    logic [ADDR_W-1:0]    adr;
    logic [31:0]          dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef enum logic [1:0] {
    REG_SOURCE = 2'b00,
    REG_EN_SET = 2'b01,
    REG_RESULT = 2'b10,
    REG_EN_CLR = 2'b11
  } group_reg_e;
endpackage
`default_nettype wire

// ===== design/irq_group_slice.sv
`default_nettype none
// one interrupt group: sticky event bits and their enables
module irq_group_slice
  import irq_agg_pkg::*;
#(
  parameter logic [SRC_BITS-1:0] IMPL_MASK = {SRC_BITS{1'b1}}
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire irq_agg_pkg::src_vec_t event_i,
  input  wire logic                 src_clr_we_i,
  input  wire logic                 en_set_we_i,
  input  wire logic                 en_clr_we_i,
  input  wire irq_agg_pkg::src_vec_t wdata_i,
  output logic [SRC_BITS-1:0]       latched_o,
  output logic [SRC_BITS-1:0]       enable_o,
  output logic [SRC_BITS-1:0]       masked_o
);
  import irq_agg_pkg::*;

  typedef struct packed {
    src_vec_t latched;
    src_vec_t enable;
  } slice_s;

  slice_s st_r;
  slice_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    // event wins over a same-cycle source clear, enable clear wins over enable set; events ignore the enables
    if (src_clr_we_i) begin
      st_nxt.latched = st_r.latched & ~wdata_i;
    end
    st_nxt.latched = (st_nxt.latched | event_i) & IMPL_MASK;
    if (en_set_we_i) begin
      st_nxt.enable = st_r.enable | (wdata_i & IMPL_MASK);
    end
    if (en_clr_we_i) begin
      st_nxt.enable = st_nxt.enable & ~wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{latched: SRC_RESET, enable: SRC_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign latched_o = st_r.latched;
  assign enable_o  = st_r.enable;
  assign masked_o  = st_r.latched & st_r.enable;

  a_event_latched : assert property (@(posedge clk_i) disable iff (rst_i)
    (event_i[0] && IMPL_MASK[0]) |=> latched_o[0])
    else $error("event not latched");
  a_zero_keeps : assert property (@(posedge clk_i) disable iff (rst_i)
    (src_clr_we_i && !wdata_i[0] && latched_o[0]) |=> latched_o[0])
    else $error("write zero cleared a source bit");
  a_enable_hold : assert property (@(posedge clk_i) disable iff (rst_i)
    (!en_set_we_i && !en_clr_we_i) |=> $stable(enable_o))
    else $error("enable changed without a write");
endmodule
`default_nettype wire

// ===== design/interrupt_group_aggregator.sv
`default_nettype none
// How it works
// - write one clears sticky source bit
// - events latch regardless of enable
// - enable-set write one sets enable
// - enable-clear write one clears enable
// - both enable registers read enable state
// - result is source AND enable, read-only
// - bit 31 and unassigned bits read zero
// - unimplemented inputs behave as reserved
// - block set register sets group enables
// - block set reads group enables
// - block clear write one disables group
// - vector register shows asserted group lines
// - wake is combinational OR of enabled sources selected by WAKE_MASK
module interrupt_group_aggregator
  import irq_agg_pkg::*;
#(
  parameter logic [SRC_BITS-1:0] IMPL_MASK = {SRC_BITS{1'b1}},
  parameter logic [SRC_BITS-1:0] WAKE_MASK = {SRC_BITS{1'b1}}
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [irq_agg_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [31:0]                  dat_i,
  output logic      [31:0]                  dat_o,
  output logic                              ack_o,
  input  wire logic [irq_agg_pkg::GROUP_COUNT*irq_agg_pkg::SRC_BITS-1:0]
                                            event_i,
  output logic [irq_agg_pkg::GROUP_COUNT-1:0] group_irq_o,
  output logic                              wake_o
);
  import irq_agg_pkg::*;

  typedef struct packed {
    logic                   ack;
    logic [31:0]            rdat;
    logic [GROUP_COUNT-1:0] blk_en;
  } top_s;

  top_s st_r;
  top_s st_nxt;

  wb_req_s req;
  logic                   req_go;
  logic                   in_groups;
  logic [4:0]             grp_idx;
  group_reg_e             grp_reg;
  logic [31:0]            wmask;
  logic [31:0]            wdata;
  logic [GROUP_COUNT-1:0] src_clr_we;
  logic [GROUP_COUNT-1:0] en_set_we;
  logic [GROUP_COUNT-1:0] en_clr_we;
  logic [GROUP_COUNT-1:0] grp_any;
  logic [GROUP_COUNT-1:0] grp_wake;
  src_vec_t               latched [GROUP_COUNT];
  src_vec_t               enable  [GROUP_COUNT];
  src_vec_t               masked  [GROUP_COUNT];

  // byte lanes to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // block registers carry group n at bit n + GROUP_FIRST
  function automatic logic [31:0] to_blk(input logic [GROUP_COUNT-1:0] v);
    to_blk = '0;
    to_blk[GROUP_LAST:GROUP_FIRST] = v;
  endfunction

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i,
                 adr: adr_i, dat: dat_i};
  // classic cycle: one ack per strobe, dropped the cycle after
  assign req_go = req.cyc && req.stb && !st_r.ack;
  assign wmask  = lane_mask(req.sel);
  assign wdata  = req.dat & wmask;

  // group window: 20-byte stride, five words per group
  always_comb begin
    logic [ADDR_W-1:0] rel;
    rel       = '0;
    grp_idx   = '0;
    grp_reg   = REG_SOURCE;
    in_groups = 1'b0;
    if (req.adr <= OFS_GROUP_END && req.adr[1:0] == 2'b00) begin
      grp_idx = 5'(req.adr / 10'(GROUP_STRIDE));
      rel     = req.adr - 10'(32'(grp_idx) * GROUP_STRIDE);
      in_groups = 1'b1;
      case (rel)
        OFS_SOURCE:   grp_reg = REG_SOURCE;
        OFS_EN_SET:   grp_reg = REG_EN_SET;
        OFS_RESULT:   grp_reg = REG_RESULT;
        OFS_EN_CLEAR: grp_reg = REG_EN_CLR;
        default:      in_groups = 1'b0;
      endcase
    end
  end

  always_comb begin
    src_clr_we = '0;
    en_set_we  = '0;
    en_clr_we  = '0;
    if (req_go && req.we && in_groups) begin
      case (grp_reg)
        REG_SOURCE: src_clr_we[grp_idx] = 1'b1;
        REG_EN_SET: en_set_we[grp_idx]  = 1'b1;
        REG_EN_CLR: en_clr_we[grp_idx]  = 1'b1;
        default:    ; // result register ignores writes
      endcase
    end
  end

  for (genvar g = 0; g < GROUP_COUNT; g++) begin : g_grp
    irq_group_slice #(
      .IMPL_MASK (IMPL_MASK)
    ) u_slice (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .event_i      (event_i[g*SRC_BITS +: SRC_BITS]),
      .src_clr_we_i (src_clr_we[g]),
      .en_set_we_i  (en_set_we[g]),
      .en_clr_we_i  (en_clr_we[g]),
      .wdata_i      (wdata[SRC_BITS-1:0]),
      .latched_o    (latched[g]),
      .enable_o     (enable[g]),
      .masked_o     (masked[g])
    );
    assign grp_any[g]  = |masked[g];
    assign grp_wake[g] = |(latched[g] & enable[g] & WAKE_MASK);
  end

  assign group_irq_o = grp_any & st_r.blk_en;
  assign wake_o      = |grp_wake;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = req_go;
    if (req_go && !req.we) begin
      st_nxt.rdat = '0; // unmapped and reserved read zero
      if (in_groups) begin
        case (grp_reg)
          REG_SOURCE: st_nxt.rdat = {1'b0, latched[grp_idx]};
          REG_EN_SET: st_nxt.rdat = {1'b0, enable[grp_idx]};
          REG_EN_CLR: st_nxt.rdat = {1'b0, enable[grp_idx]};
          REG_RESULT: st_nxt.rdat = {1'b0, masked[grp_idx]};
          default:    st_nxt.rdat = '0;
        endcase
      end else if (req.adr == OFS_BLK_SET || req.adr == OFS_BLK_CLEAR) begin
        st_nxt.rdat = to_blk(st_r.blk_en);
      end else if (req.adr == OFS_BLK_VEC) begin
        st_nxt.rdat = to_blk(group_irq_o);
      end
    end
    if (req_go && req.we && req.adr == OFS_BLK_SET) begin
      st_nxt.blk_en = st_r.blk_en | wdata[GROUP_LAST:GROUP_FIRST];
    end
    if (req_go && req.we && req.adr == OFS_BLK_CLEAR) begin
      st_nxt.blk_en = st_r.blk_en & ~wdata[GROUP_LAST:GROUP_FIRST];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{ack: 1'b0, rdat: 32'h0, blk_en: BLK_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ack_o = st_r.ack;
  assign dat_o = st_r.rdat;

  a_ack_one : assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_ack_follows : assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not answered next cycle");
  a_blk_set : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_go && we_i && adr_i == OFS_BLK_SET && sel_i[1] && dat_i[8])
      |=> st_r.blk_en[0])
    else $error("block set did not enable group");
  a_blk_clear : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_go && we_i && adr_i == OFS_BLK_CLEAR && sel_i[1] && dat_i[8])
      |=> !st_r.blk_en[0] && !group_irq_o[0])
    else $error("block clear did not disable group");
  a_group_line : assert property (@(posedge clk_i) disable iff (rst_i)
    group_irq_o[0] == ((|(latched[0] & enable[0])) && st_r.blk_en[0]))
    else $error("group line mismatch");
  a_read_reserved : assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> dat_o[31] == 1'b0)
    else $error("reserved bit read nonzero");
  a_result_read : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_go && !we_i && adr_i == OFS_RESULT)
      |=> dat_o[SRC_BITS-1:0] == $past(masked[0]))
    else $error("result read mismatch");
  a_enable_read : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_go && !we_i && adr_i == OFS_EN_CLEAR)
      |=> dat_o[SRC_BITS-1:0] == $past(enable[0]))
    else $error("enable clear read mismatch");
  a_blk_read : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_go && !we_i && adr_i == OFS_BLK_SET)
      |=> dat_o[GROUP_LAST:GROUP_FIRST] == $past(st_r.blk_en))
    else $error("block enable read mismatch");
  a_wake_comb : assert property (@(posedge clk_i) disable iff (rst_i)
    wake_o == (|grp_wake))
    else $error("wake mismatch");
  a_vec_read : assert property (@(posedge clk_i) disable iff (rst_i)
    (req_go && !we_i && adr_i == OFS_BLK_VEC)
      |=> dat_o[GROUP_LAST:GROUP_FIRST] == $past(group_irq_o))
    else $error("vector read mismatch");
endmodule
`default_nettype wire

// ===== sim/event_source_model.sv
`default_nettype none
// raw event pulses toward the aggregator
module event_source_model (
  input  wire logic clk_i,
  output logic [irq_agg_pkg::GROUP_COUNT*irq_agg_pkg::SRC_BITS-1:0] event_o
);
  import irq_agg_pkg::*;

  initial event_o = '0;

  // one-cycle pulse, sent whatever the enables hold
  task automatic fire(input int idx);
    @(posedge clk_i);
    event_o[idx] <= 1'b1;
    @(posedge clk_i);
    event_o[idx] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== sim/interrupt_group_aggregator_tb.sv
`default_nettype none
module interrupt_group_aggregator_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_agg_pkg::*;

  logic                         clk_i = 1'b0;
  logic                         rst_i = 1'b1;
  logic                         cyc_i = 1'b0;
  logic                         stb_i = 1'b0;
  logic                         we_i  = 1'b0;
  logic [3:0]                   sel_i = 4'h0;
  logic [ADDR_W-1:0]            adr_i = '0;
  logic [31:0]                  dat_i = 32'h0;
  logic [31:0]                  dat_o;
  logic                         ack_o;
  logic [GROUP_COUNT*SRC_BITS-1:0] event_i;
  logic [GROUP_COUNT-1:0]       group_irq_o;
  logic                         wake_o;
  int                           num_errors = 0;
  int                           compares = 0;

  always #25 clk_i = ~clk_i;

  event_source_model u_event_source_model (.clk_i(clk_i), .event_o(event_i));

  // source bit 0 of every group left unimplemented
  interrupt_group_aggregator #(.IMPL_MASK(31'h7fff_fffe))
  u_interrupt_group_aggregator (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .event_i(event_i),
    .group_irq_o(group_irq_o), .wake_o(wake_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // single classic cycle, released at the edge that samples ack
  task automatic wb(input logic w, input logic [ADDR_W-1:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'hf;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, 32'h0, 32'h1);
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic t_latch();
    rd(10'h200, 32'h0);
    rd(10'h004, 32'h0);
    u_event_source_model.fire(3);
    rd(10'h000, 32'h8);
    rd(10'h008, 32'h0);
  endtask

  task automatic t_enable();
    wr(10'h004, 32'h9);
    rd(10'h004, 32'h8);
    rd(10'h00c, 32'h8);
    wr(10'h008, 32'hffff_ffff);
    rd(10'h008, 32'h8);
    wr(10'h00c, 32'h8);
    rd(10'h004, 32'h0);
    rd(10'h008, 32'h0);
    wr(10'h004, 32'h8);
  endtask

  task automatic t_block();
    chk({31'h0, wake_o}, 32'h1);
    chk({13'h0, group_irq_o}, 32'h0);
    wr(10'h200, 32'hffff_ffff);
    rd(10'h200, 32'h07ff_ff00);
    chk({13'h0, group_irq_o}, 32'h1);
    rd(10'h208, 32'h0000_0100);
    wr(10'h204, 32'h0000_0100);
    rd(10'h204, 32'h07ff_fe00);
    rd(10'h208, 32'h0);
    chk({13'h0, group_irq_o}, 32'h0);
  endtask

  task automatic t_clear();
    wr(10'h000, 32'h8000_0000);
    rd(10'h000, 32'h8);
    wr(10'h000, 32'h8);
    rd(10'h000, 32'h0);
    chk({31'h0, wake_o}, 32'h0);
    u_event_source_model.fire(18 * 31 + 30);
    rd(10'h168, 32'h4000_0000);
    rd(10'h010, 32'h0);
    rd(10'h210, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_latch();
    t_enable();
    t_block();
    t_clear();
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
